/* File: verilog/tppl_latch.sv */
// Dual touch probe position latch with status and captured positions
module tppl_latch
	import tppl_pkg::*;
#(
	parameter int POS_W   = 32, // Width of the feedback position
	parameter int CTL_W   = 16, // Width of control and status words
	parameter int PROBES  = 2   // Number of probe channels
)
(
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst,
	// Assignable input terminals, from pins
	input  wire logic                    assignable_terminal_a,
	input  wire logic                    assignable_terminal_b,
	// Encoder zero pulse and feedback position, same clock domain
	input  wire logic                    encoder_zero_pulse,
	input  wire logic signed [POS_W-1:0] feedback_position,
	// Probe control word, written by the fieldbus master
	input  wire logic [CTL_W-1:0]        probe_function_word,
	// Boot-time configuration, caught once after reset release
	input  wire logic [3:0]              terminal_a_signal_select,
	input  wire logic [3:0]              terminal_b_signal_select,
	input  wire logic                    terminal_a_invert,
	input  wire logic                    terminal_b_invert,
	input  wire logic [7:0]              probe_filter_time,
	// Results read by the fieldbus master
	output logic [CTL_W-1:0]             probe_status_word,
	output logic signed [POS_W-1:0]      probe_one_rise_position,
	output logic signed [POS_W-1:0]      probe_one_fall_position,
	output logic signed [POS_W-1:0]      probe_two_rise_position,
	output logic signed [POS_W-1:0]      probe_two_fall_position
);

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------

	// Control field of one probe from the control word
	function automatic logic ctl_bit(input logic [CTL_W-1:0] word, input int probe,
		input int field);
		ctl_bit = word[probe * TPPL_PROBE_STRIDE + field];
	endfunction : ctl_bit

	// Filter time units to clock cycles, rounded up
	function automatic logic [TPPL_FILT_CNT_W-1:0] filt_to_cycles(input logic [7:0] units);
		logic [7:0] lim;
		lim = (units > TPPL_FILT_MAX) ? TPPL_FILT_MAX : units;
		filt_to_cycles = TPPL_FILT_CNT_W'((32'(lim) * TPPL_FILT_UNIT_NS
			+ TPPL_CLK_PERIOD_NS - 1) / TPPL_CLK_PERIOD_NS);
	endfunction : filt_to_cycles

	// ------------------------------------------------------------
	// Boot-time configuration
	// ------------------------------------------------------------
	logic                       cfg_load_ff;   // Load pending after reset
	logic                       cfg_fresh_ff;  // New settings first visible
	logic [3:0]                 sel_a_ff;      // Terminal a routing
	logic [3:0]                 sel_b_ff;      // Terminal b routing
	logic                       inv_a_ff;      // Terminal a inversion
	logic                       inv_b_ff;      // Terminal b inversion
	logic [TPPL_FILT_CNT_W-1:0] filt_cyc_ff;   // Filter length in cycles

	// Pending flag: armed by reset, cleared once the settings are taken
	always_ff @(posedge clk)
	begin
		if (rst)
			cfg_load_ff <= 1'b1;
		else
			cfg_load_ff <= 1'b0;
	end

	// Marks the cycle in which new routing first reaches the probe inputs
	always_ff @(posedge clk)
	begin
		if (rst)
			cfg_fresh_ff <= 1'b0;
		else
			cfg_fresh_ff <= cfg_load_ff;
	end

	// Settings load defaults in reset, then change only on the first cycle after a restart
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			// Defaults stand until the first load
			sel_a_ff    <= TPPL_SEL_A_DEFAULT;
			sel_b_ff    <= TPPL_SEL_B_DEFAULT;
			inv_a_ff    <= TPPL_INV_DEFAULT;
			inv_b_ff    <= TPPL_INV_DEFAULT;
			filt_cyc_ff <= filt_to_cycles(TPPL_FILT_DEFAULT);
		end
		else if (cfg_load_ff)
		begin
			// Take the boot settings once
			sel_a_ff    <= terminal_a_signal_select;
			sel_b_ff    <= terminal_b_signal_select;
			inv_a_ff    <= terminal_a_invert;
			inv_b_ff    <= terminal_b_invert;
			filt_cyc_ff <= filt_to_cycles(probe_filter_time);
		end
	end

	// ------------------------------------------------------------
	// Terminal filtering and routing
	// ------------------------------------------------------------
	logic       filt_a;          // Filtered terminal a level
	logic       filt_b;          // Filtered terminal b level
	logic       active_a;        // Terminal a active, after inversion
	logic       active_b;        // Terminal b active, after inversion
	logic [1:0] probe_pin;       // Active level of each probe input

	// Terminal a glitch filter
	tppl_pin_filter #(
		.CNT_W       (TPPL_FILT_CNT_W)
	) u_filter_a (
		.clk         (clk),
		.rst         (rst),
		.pin_raw     (assignable_terminal_a),
		.filt_cycles (filt_cyc_ff),
		.filt_level  (filt_a)
	);

	// Terminal b glitch filter
	tppl_pin_filter #(
		.CNT_W       (TPPL_FILT_CNT_W)
	) u_filter_b (
		.clk         (clk),
		.rst         (rst),
		.pin_raw     (assignable_terminal_b),
		.filt_cycles (filt_cyc_ff),
		.filt_level  (filt_b)
	);

	// Invert 0: low level is active; invert 1: high level is active
	assign active_a = inv_a_ff ? filt_a : ~filt_a;
	assign active_b = inv_b_ff ? filt_b : ~filt_b;

	// Each probe input takes any terminal routed to it
	always_comb
	begin
		probe_pin[0] = (active_a && sel_a_ff == TPPL_SEL_PROBE_ONE)
			|| (active_b && sel_b_ff == TPPL_SEL_PROBE_ONE);
		probe_pin[1] = (active_a && sel_a_ff == TPPL_SEL_PROBE_TWO)
			|| (active_b && sel_b_ff == TPPL_SEL_PROBE_TWO);
	end

	// ------------------------------------------------------------
	// Zero pulse history, shared by both probes
	// ------------------------------------------------------------
	logic zero_prev_ff;   // Zero pulse one cycle ago

	// Keep last zero pulse level for edge detection
	always_ff @(posedge clk)
	begin
		if (rst)
			zero_prev_ff <= 1'b0;
		else
			zero_prev_ff <= encoder_zero_pulse;
	end

	// ------------------------------------------------------------
	// Probe channels
	// ------------------------------------------------------------
	logic [PROBES-1:0]             enabled;       // Enable bit per probe
	logic [PROBES-1:0]             rise_hold_ff;  // Rising capture held
	logic [PROBES-1:0]             fall_hold_ff;  // Falling capture held
	logic [1:0]                    exec_cnt_ff [PROBES];  // Execution counts
	logic signed [POS_W-1:0]       rise_pos_ff [PROBES];  // Rising captures
	logic signed [POS_W-1:0]       fall_pos_ff [PROBES];  // Falling captures

	genvar gp;
	generate
		for (gp = 0; gp < PROBES; gp++)
		begin : g_probe
			logic en;           // Probe enabled
			logic cont;         // Continuous mode
			logic src_zero;     // Zero pulse is the trigger
			logic rise_en;      // Rising edge sampling on
			logic fall_en;      // Falling edge sampling on
			logic trig;         // Selected trigger level now
			logic trig_prev;    // Trigger level one cycle ago
			logic pin_prev_ff;  // Pin level one cycle ago
			logic en_prev_ff;   // Enable one cycle ago
			logic rise_evt;     // Qualifying rising edge
			logic fall_evt;     // Qualifying falling edge
			logic rise_take;    // Rising capture happens now
			logic fall_take;    // Falling capture happens now

			// Decode this probe's control fields
			assign en       = ctl_bit(probe_function_word, gp, TPPL_CTL_ENABLE);
			assign cont     = ctl_bit(probe_function_word, gp, TPPL_CTL_MODE);
			assign src_zero = ctl_bit(probe_function_word, gp, TPPL_CTL_SOURCE);
			assign rise_en  = ctl_bit(probe_function_word, gp, TPPL_CTL_RISE_EN);
			assign fall_en  = ctl_bit(probe_function_word, gp, TPPL_CTL_FALL_EN);
			assign enabled[gp] = en;

			// Trigger source: filtered pin or encoder zero pulse
			always_comb
			begin
				if (src_zero)
				begin
					trig = encoder_zero_pulse;
				end
				else
				begin
					trig = probe_pin[gp];
				end
			end

			// History of pin level and enable for edge detection
			always_ff @(posedge clk)
			begin
				if (rst)
				begin
					pin_prev_ff <= 1'b0;
					en_prev_ff  <= 1'b0;
				end
				else
				begin
					pin_prev_ff <= probe_pin[gp];
					en_prev_ff  <= en;
				end
			end

			// Previous level of whichever source is selected
			// Pin history still shows the old routing right after a restart:
			// treat that cycle as level, so a new inversion is not an edge
			assign trig_prev = src_zero ? zero_prev_ff
				: (cfg_fresh_ff ? probe_pin[gp] : pin_prev_ff);

			// Edges count only while enabled and sampling is on
			assign rise_evt = en && rise_en && trig && !trig_prev;
			assign fall_evt = en && fall_en && !trig && trig_prev;

			// Single mode takes only the first event of each edge
			assign rise_take = rise_evt && (cont || !rise_hold_ff[gp]);
			assign fall_take = fall_evt && (cont || !fall_hold_ff[gp]);

			// Stored flags: cleared while disabled or on re-enable
			always_ff @(posedge clk)
			begin
				if (rst)
				begin
					rise_hold_ff[gp] <= 1'b0;
					fall_hold_ff[gp] <= 1'b0;
				end
				else if (!en || !en_prev_ff)
				begin
					// Disabled, or first enabled cycle: start clean
					rise_hold_ff[gp] <= 1'b0;
					fall_hold_ff[gp] <= 1'b0;
				end
				else
				begin
					// Set together with the captured position
					if (rise_take)
						rise_hold_ff[gp] <= 1'b1;
					if (fall_take)
						fall_hold_ff[gp] <= 1'b1;
				end
			end

			// Execution counter, continuous mode only, wraps 3 to 0
			always_ff @(posedge clk)
			begin
				if (rst)
					exec_cnt_ff[gp] <= 2'h0;
				else if (!en || !en_prev_ff)
					exec_cnt_ff[gp] <= 2'h0;
				else if (cont && (rise_take || fall_take))
					exec_cnt_ff[gp] <= exec_cnt_ff[gp] + 2'h1;
			end

			// Copy the feedback position on a taken edge
			always_ff @(posedge clk)
			begin
				if (rst)
				begin
					rise_pos_ff[gp] <= '0;
					fall_pos_ff[gp] <= '0;
				end
				else
				begin
					if (rise_take && en_prev_ff)
						rise_pos_ff[gp] <= feedback_position;
					if (fall_take && en_prev_ff)
						fall_pos_ff[gp] <= feedback_position;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Status word and position outputs
	// ------------------------------------------------------------
	logic [CTL_W-1:0] status_ff;   // Registered status word

	// Assemble the status word; reserved bits read zero
	always_ff @(posedge clk)
	begin
		if (rst)
			status_ff <= '0;
		else
		begin
			status_ff <= '0;
			status_ff[TPPL_STS_ENABLED]  <= enabled[0];
			status_ff[TPPL_STS_RISE_HLD] <= rise_hold_ff[0];
			status_ff[TPPL_STS_FALL_HLD] <= fall_hold_ff[0];
			status_ff[TPPL_STS_COUNT_LO +: 2] <= exec_cnt_ff[0];
			status_ff[TPPL_PROBE_STRIDE + TPPL_STS_ENABLED]  <= enabled[1];
			status_ff[TPPL_PROBE_STRIDE + TPPL_STS_RISE_HLD] <= rise_hold_ff[1];
			status_ff[TPPL_PROBE_STRIDE + TPPL_STS_FALL_HLD] <= fall_hold_ff[1];
			status_ff[TPPL_PROBE_STRIDE + TPPL_STS_COUNT_LO +: 2] <= exec_cnt_ff[1];
		end
	end

	assign probe_status_word       = status_ff;
	assign probe_one_rise_position = rise_pos_ff[0];
	assign probe_one_fall_position = fall_pos_ff[0];
	assign probe_two_rise_position = rise_pos_ff[1];
	assign probe_two_fall_position = fall_pos_ff[1];

endmodule : tppl_latch

/* File: inc/tppl_pkg.sv */
// Package of constants for the touch probe position latch
package tppl_pkg;

	// ------------------------------------------------------------
	// Object indices of the control word and the readable results
	// ------------------------------------------------------------
	localparam logic [15:0] TPPL_IDX_FUNCTION  = 16'h60B8; // Probe control word
	localparam logic [15:0] TPPL_IDX_STATUS    = 16'h60B9; // Probe status word
	localparam logic [15:0] TPPL_IDX_ONE_RISE  = 16'h60BA; // Probe one rising capture
	localparam logic [15:0] TPPL_IDX_ONE_FALL  = 16'h60BB; // Probe one falling capture
	localparam logic [15:0] TPPL_IDX_TWO_RISE  = 16'h60BC; // Probe two rising capture
	localparam logic [15:0] TPPL_IDX_TWO_FALL  = 16'h60BD; // Probe two falling capture

	// ------------------------------------------------------------
	// Field layout, per probe, relative to the probe's byte
	// ------------------------------------------------------------
	localparam int TPPL_PROBE_STRIDE = 8; // Probe two sits 8 bits higher
	localparam int TPPL_CTL_ENABLE   = 0; // Control: enable
	localparam int TPPL_CTL_MODE     = 1; // Control: 0 single, 1 continuous
	localparam int TPPL_CTL_SOURCE   = 2; // Control: 0 pin, 1 zero pulse
	localparam int TPPL_CTL_RISE_EN  = 4; // Control: rising edge sampling
	localparam int TPPL_CTL_FALL_EN  = 5; // Control: falling edge sampling
	localparam int TPPL_STS_ENABLED  = 0; // Status: enabled
	localparam int TPPL_STS_RISE_HLD = 1; // Status: rising capture held
	localparam int TPPL_STS_FALL_HLD = 2; // Status: falling capture held
	localparam int TPPL_STS_COUNT_LO = 6; // Status: execution count, low bit

	// ------------------------------------------------------------
	// Terminal configuration values and defaults
	// ------------------------------------------------------------
	localparam logic [3:0] TPPL_SEL_PROBE_ONE = 4'h8; // Route terminal to probe one
	localparam logic [3:0] TPPL_SEL_PROBE_TWO = 4'h9; // Route terminal to probe two
	localparam logic [3:0] TPPL_SEL_A_DEFAULT = 4'h8; // Terminal a default routing
	localparam logic [3:0] TPPL_SEL_B_DEFAULT = 4'h9; // Terminal b default routing
	localparam logic       TPPL_INV_DEFAULT   = 1'b0; // Default: active low
	localparam logic [7:0] TPPL_FILT_DEFAULT  = 8'h14; // Default filter time, 20 units
	localparam logic [7:0] TPPL_FILT_MAX      = 8'hC8; // Largest filter time, 200 units
	localparam logic       TPPL_PIN_IDLE      = 1'b1; // Pin level assumed at reset

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int TPPL_FILT_UNIT_NS = 10; // One filter time unit, ns
	localparam int TPPL_CLK_PERIOD_NS = 4; // Clock period, ns
	localparam int TPPL_FILT_CNT_W   = 9;  // Width of filter cycle counts
	localparam logic [TPPL_FILT_CNT_W-1:0] TPPL_FILT_CYC_MAX = TPPL_FILT_CNT_W'(
		(200 * TPPL_FILT_UNIT_NS + TPPL_CLK_PERIOD_NS - 1) / TPPL_CLK_PERIOD_NS);

endpackage : tppl_pkg

/* File: verilog/tppl_pin_filter.sv */
// Synchroniser and glitch filter for one probe input terminal
module tppl_pin_filter
	import tppl_pkg::*;
#(
	parameter int CNT_W = TPPL_FILT_CNT_W
)
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Raw pin and filter length
	input  wire logic             pin_raw,
	input  wire logic [CNT_W-1:0] filt_cycles,
	// Filtered level
	output logic                  filt_level
);

	// ------------------------------------------------------------
	// Synchroniser
	// ------------------------------------------------------------
	logic             sync1_ff;   // First stage, read only by stage two
	logic             sync2_ff;   // Second stage
	logic             sync3_ff;   // Third stage
	logic [CNT_W-1:0] stable_ff;  // Cycles the new level has stood
	logic             level_ff;   // Accepted filtered level

	// Three flops; a level counts once stages two and three agree
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sync1_ff <= TPPL_PIN_IDLE;
			sync2_ff <= TPPL_PIN_IDLE;
			sync3_ff <= TPPL_PIN_IDLE;
		end
		else
		begin
			sync1_ff <= pin_raw;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
		end
	end

	// ------------------------------------------------------------
	// Filter: accept a new level after it stood filt_cycles cycles
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			stable_ff <= '0;
			level_ff  <= TPPL_PIN_IDLE;
		end
		else if (sync2_ff != sync3_ff || sync3_ff == level_ff)
		begin
			// Still moving or unchanged: restart the count
			stable_ff <= '0;
		end
		else if (stable_ff >= filt_cycles)
		begin
			// Stood long enough: take it
			level_ff  <= sync3_ff;
			stable_ff <= '0;
		end
		else
		begin
			stable_ff <= stable_ff + 1'b1;
		end
	end

	assign filt_level = level_ff;

endmodule : tppl_pin_filter

/* File: dv/tppl_latch_checker.sv */
// Port-level assertions for the touch probe position latch
module tppl_latch_checker
#(
	parameter int POS_W = 32, // Position width
	parameter int CTL_W = 16  // Control and status width
)
(
	// Clock and reset
	input wire logic                    clk,
	input wire logic                    rst,
	// Trigger source and control
	input wire logic                    encoder_zero_pulse,
	input wire logic signed [POS_W-1:0] feedback_position,
	input wire logic [CTL_W-1:0]        probe_function_word,
	// Results
	input wire logic [CTL_W-1:0]        probe_status_word,
	input wire logic signed [POS_W-1:0] probe_one_rise_position,
	input wire logic signed [POS_W-1:0] probe_two_fall_position
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// ------------------------------------------------------------
	// Enable and flag reporting
	// ------------------------------------------------------------
	enable_one_a: assert property (
		!$past(rst) && $stable(probe_function_word[0])
		|=> probe_status_word[0] == $past(probe_function_word[0]))
		else $error("probe one enable flag wrong");
	enable_two_a: assert property (
		!$past(rst) && $stable(probe_function_word[8])
		|=> probe_status_word[8] == $past(probe_function_word[8]))
		else $error("probe two enable flag wrong");
	idle_clear_a: assert property (
		!probe_function_word[0] ##1 !probe_function_word[0]
		|=> probe_status_word[2:1] == 2'h0 && probe_status_word[7:6] == 2'h0)
		else $error("probe one flags not cleared while disabled");
	one_rise_flag_a: assert property (
		!$past(rst) && !$stable(probe_one_rise_position) |=> probe_status_word[1])
		else $error("rise capture without rise flag");
	two_fall_flag_a: assert property (
		!$past(rst) && !$stable(probe_two_fall_position) |=> probe_status_word[10])
		else $error("fall capture without fall flag");

	// ------------------------------------------------------------
	// Capture value and gating
	// ------------------------------------------------------------
	zero_one_a: assert property (
		probe_function_word[5:0] == 6'h17 && $stable(probe_function_word)
		&& $past(probe_function_word[0]) && !$past(rst) && $rose(encoder_zero_pulse)
		|=> probe_one_rise_position == $past(feedback_position))
		else $error("zero pulse rise not captured");
	zero_two_a: assert property (
		probe_function_word[13:8] == 6'h27 && $stable(probe_function_word)
		&& $past(probe_function_word[8]) && !$past(rst) && $fell(encoder_zero_pulse)
		|=> probe_two_fall_position == $past(feedback_position))
		else $error("zero pulse fall not captured");
	disabled_keep_a: assert property (
		!probe_function_word[8] |=> $stable(probe_two_fall_position))
		else $error("capture while probe two disabled");
	single_hold_a: assert property (
		probe_function_word[1:0] == 2'h1 && $past(probe_function_word[1:0]) == 2'h1
		&& probe_status_word[1] |=> $stable(probe_one_rise_position))
		else $error("single mode capture overwritten");

	// ------------------------------------------------------------
	// Execution counters
	// ------------------------------------------------------------
	count_one_a: assert property (
		!$past(rst) && $changed(probe_status_word[7:6]) && probe_status_word[7:6] != 2'h0
		|-> probe_status_word[7:6] == $past(probe_status_word[7:6]) + 2'h1)
		else $error("probe one count skipped");
	count_two_a: assert property (
		!$past(rst) && $changed(probe_status_word[15:14]) && probe_status_word[15:14] != 2'h0
		|-> probe_status_word[15:14] == $past(probe_status_word[15:14]) + 2'h1)
		else $error("probe two count skipped");
endmodule : tppl_latch_checker

bind tppl_latch tppl_latch_checker #(.POS_W(POS_W), .CTL_W(CTL_W)) tppl_latch_checker_inst (
	.clk(clk), .rst(rst), .encoder_zero_pulse(encoder_zero_pulse),
	.feedback_position(feedback_position), .probe_function_word(probe_function_word),
	.probe_status_word(probe_status_word), .probe_one_rise_position(probe_one_rise_position),
	.probe_two_fall_position(probe_two_fall_position)
);

/* File: dv/tppl_sensor_model.sv */
// Model of the two switches wired to the assignable terminals
module tppl_sensor_model
(
	// Clock for timing the contacts
	input  wire logic clk,
	// Contact levels at the terminals
	output logic      pin_a = 1'b0,
	output logic      pin_b = 1'b1
);
	timeunit 1ns;
	timeprecision 1ps;

	// Move both contacts just after an edge
	task automatic set_pins(input logic a, input logic b);
		@(posedge clk);
		pin_a <= a;
		pin_b <= b;
	endtask : set_pins

	// Short contact bounce, then back to rest
	task automatic bounce(input logic a, input logic b, input int cycles);
		set_pins(a, b);
		repeat (cycles) @(posedge clk);
		pin_a <= ~a;
		pin_b <= ~b;
	endtask : bounce
endmodule : tppl_sensor_model

/* File: dv/tppl_latch_tb.sv */
// Self-checking testbench for the touch probe position latch
module tppl_latch_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic               clk = 1'b0;   // Clock
	logic               rst = 1'b1;   // Reset
	logic               zero = 1'b0;  // Zero pulse
	logic signed [31:0] fb = 32'sh0;  // Feedback position
	logic [15:0]        ctl = 16'h0;  // Control word
	logic               pin_a, pin_b; // Terminals
	logic [15:0]        status;       // Status word
	logic signed [31:0] one_r, one_f, two_r, two_f, last_p, held_p;
	logic [3:0]         sel_a = 4'h8; // Terminal a routing
	logic [3:0]         sel_b = 4'h9; // Terminal b routing
	logic               inv_a = 1'b1; // Terminal a inversion
	logic               inv_b = 1'b0; // Terminal b inversion
	logic [7:0]         filt = 8'h14; // Filter time units
	logic [1:0]         c1, c2;       // Expected counts
	int                 fail_count = 0;
	int                 check_count = 0;
	int                 n;

	initial forever #2 clk = ~clk;

	tppl_latch tppl_latch_inst (
		.clk(clk), .rst(rst), .assignable_terminal_a(pin_a), .assignable_terminal_b(pin_b),
		.encoder_zero_pulse(zero), .feedback_position(fb), .probe_function_word(ctl),
		.terminal_a_signal_select(sel_a), .terminal_b_signal_select(sel_b),
		.terminal_a_invert(inv_a), .terminal_b_invert(inv_b), .probe_filter_time(filt),
		.probe_status_word(status), .probe_one_rise_position(one_r),
		.probe_one_fall_position(one_f), .probe_two_rise_position(two_r),
		.probe_two_fall_position(two_f)
	);
	tppl_sensor_model tppl_sensor_model_inst (.clk(clk), .pin_a(pin_a), .pin_b(pin_b));

	// Verdict and end of run
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop

	// One comparison
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// Expected status byte of one probe
	function automatic logic [7:0] sts_byte(input logic en, input logic r, input logic f,
		input logic [1:0] c);
		return {c, 3'h0, f, r, en};
	endfunction : sts_byte

	// Cycles from pin change to status flag: sync, 10 ns units at 4 ns, capture, status
	function automatic int pin_delay(input int units);
		return (units * 10 + 3) / 4 + 6;
	endfunction : pin_delay

	// Zero pulse edge with a random position
	task automatic zero_edge(input logic lvl);
		@(posedge clk);
		last_p = $signed($urandom);
		zero <= lvl;
		fb <= last_p;
		@(posedge clk);
		fb <= $signed($urandom);
		@(posedge clk);
		#1;
	endtask : zero_edge

	// Bounded wait for a status bit
	task automatic wait_bit(input int b);
		n = 0;
		while (status[b] !== 1'b1 && n < 200)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 200)
		begin
			fail_count++;
			$display("wrong value at %0t: status bit %0d never set", $time, b);
		end
	endtask : wait_bit

	// Write the control word at an edge
	task automatic set_ctl(input logic [15:0] v);
		@(posedge clk);
		ctl <= v;
		repeat (3) @(posedge clk);
		#1;
	endtask : set_ctl

	// Main sequence
	initial
	begin
		void'($urandom(32'hE1620529));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (100) @(posedge clk);
		#1;
		chk({16'h0, status}, 32'h0, "status after reset");
		chk(one_r | one_f | two_r | two_f, 32'h0, "positions after reset");
		// Continuous: probe one rises, probe two falls
		set_ctl(16'h2717);
		c1 = 2'h0;
		c2 = 2'h0;
		for (int i = 0; i < 6; i++)
		begin
			zero_edge(1'b1);
			c1++;
			chk(one_r, last_p, "one rise");
			chk(one_f | two_r, 32'h0, "edge not enabled");
			chk({16'h0, status}, {16'h0, sts_byte(1, 0, i > 0, c2), sts_byte(1, 1, 0, c1)},
				"status after rise");
			zero_edge(1'b0);
			c2++;
			chk(two_f, last_p, "two fall");
			chk({16'h0, status}, {16'h0, sts_byte(1, 0, 1, c2), sts_byte(1, 1, 0, c1)},
				"status after fall");
		end
		// Single mode on both probes
		set_ctl(16'h0000);
		chk({16'h0, status}, 32'h0, "disabled status");
		set_ctl(16'h3535);
		zero_edge(1'b1);
		chk(one_r, last_p, "single one rise");
		chk(two_r, last_p, "single two rise");
		zero_edge(1'b0);
		chk(one_f, last_p, "single one fall");
		chk(two_f, last_p, "single two fall");
		held_p = two_r;
		zero_edge(1'b1);
		chk(two_r, held_p, "second rise refused");
		chk(one_r, held_p, "probe one rise refused");
		chk({16'h0, status}, 32'h0707, "single status");
		// Pin path through the filter
		set_ctl(16'h0000);
		set_ctl(16'h3131);
		tppl_sensor_model_inst.bounce(1'b1, 1'b0, 20);
		repeat (80) @(posedge clk);
		#1;
		chk({16'h0, status}, 32'h0101, "short pulse filtered");
		@(posedge clk);
		last_p = $signed($urandom);
		fb <= last_p;
		tppl_sensor_model_inst.set_pins(1'b1, 1'b0);
		wait_bit(1);
		chk(32'(n >= 52 && n <= 60), 32'h1, "filter delay");
		chk(one_r, last_p, "terminal a high");
		chk(two_r, last_p, "terminal b low");
		chk({16'h0, status}, 32'h0303, "pin rise status");
		@(posedge clk);
		last_p = $signed($urandom);
		fb <= last_p;
		tppl_sensor_model_inst.set_pins(1'b0, 1'b1);
		wait_bit(2);
		chk(one_f, last_p, "terminal a fall");
		chk(two_f, last_p, "terminal b fall");
		chk({16'h0, status}, 32'h0707, "pin fall status");
		// Restart with swapped routing and inversion and a random short filter
		@(posedge clk);
		rst   <= 1'b1;
		ctl   <= 16'h0;
		sel_a <= 4'h9;
		sel_b <= 4'h8;
		inv_a <= 1'b0;
		inv_b <= 1'b1;
		filt  <= 8'($urandom_range(12));
		tppl_sensor_model_inst.set_pins(1'b1, 1'b0);
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (50) @(posedge clk);
		#1;
		chk({16'h0, status}, 32'h0, "status after restart");
		chk(one_r | one_f | two_r | two_f, 32'h0, "positions after restart");
		set_ctl(16'h3131);
		@(posedge clk);
		last_p = $signed($urandom);
		fb <= last_p;
		tppl_sensor_model_inst.set_pins(1'b0, 1'b1);
		wait_bit(1);
		chk(n, pin_delay(filt), "short filter delay");
		chk(one_r, last_p, "terminal b to probe one");
		chk(two_r, last_p, "terminal a to probe two");
		chk({16'h0, status}, 32'h0303, "inverted terminals status");
		report_and_stop();
	end

	// Watchdog against a hang
	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		report_and_stop();
	end
endmodule : tppl_latch_tb
